// File: verilog/cirt_regs.v
// Purpose: Context interrupt channels, context control and run-time timers behind an Avalon-MM slave
// Assumes: Interrupt pins asynchronous to sys_clk; core inputs synchronous
// Notes:   Five contexts, eight external channels, one soft interrupt per context
//
// The implementer's own choices: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`include "cirt_map.vh"

////////////////////////////////////////////////////////////////////////////////
module cirt_regs #(
    parameter NCTX  = 5,
    parameter NCHAN = 8
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             rst_n,
    // Avalon-MM slave
    input  wire [7:0]       avs_address,
    input  wire             avs_read,
    input  wire             avs_write,
    input  wire [31:0]      avs_writedata,
    output reg  [31:0]      avs_readdata,
    output wire             avs_waitrequest,
    // Interrupt pins
    input  wire [NCHAN-1:0] irq_pin,
    // Core side
    input  wire [NCTX-1:0]  ctx_running,
    output reg  [NCTX-1:0]  ctx_wake,
    output reg  [NCTX-1:0]  ctx_stack,
    output reg  [NCTX-1:0]  ctx_vector,
    output reg  [NCTX-1:0]  ctx_overtime,
    output reg  [NCTX*2-1:0] ctx_state
);

    localparam CW = 16;

    // Storage
    reg  [1:0]        pin_meta_reg [0:NCHAN-1];
    reg  [NCHAN-1:0]  pin_sync_reg;
    reg  [NCHAN-1:0]  pin_prev_reg;
    reg  [13:0]       chan_reg     [0:NCHAN-1];
    reg  [NCHAN-1:0]  chan_pend_reg;
    reg  [CW-1:0]     ctrl_reg     [0:NCTX-1];
    reg  [2:0]        mask_reg     [0:NCTX-1];
    reg  [13:0]       soft_reg     [0:NCTX-1];
    reg  [NCTX-1:0]   soft_pend_reg;
    reg  [31:0]       soft_sig_reg [0:NCTX-1];
    reg  [23:0]       cnt_reg      [0:NCTX-1];
    reg  [23:0]       idle_cnt_reg;
    reg  [NCTX-1:0]   run_reg;
    reg  [NCTX-1:0]   slice_reg;
    reg               idle_en_reg;
    reg  [14:0]       limit_reg;
    reg  [7:0]        fault_ctx_reg;
    reg  [3:0]        div_reg;
    reg               ack_reg;
    reg  [NCTX-1:0]   ovt_seen_reg;

    // Last divider state of each sixteen-clock period
    wire              tick = (div_reg == `CIRT_TICK_LAST);
    wire              rd_go = avs_read & ~ack_reg;
    wire              wr_go = avs_write & ~ack_reg;
    wire [23:0]       limit_full = {limit_reg, 9'h000};

    // One wait state per access, read data registered
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and channel pending logic
    genvar gi;
    generate
        for (gi = 0; gi < NCHAN; gi = gi + 1) begin : g_chan
            localparam integer CH_A = `CIRT_CHAN_BASE + gi * 4;
            wire [7:0] ch_addr = CH_A[7:0];
            wire       lvl = ~(pin_sync_reg[gi] ^ chan_reg[gi][`CIRT_POL_BIT]);
            wire       edg = lvl & ~(~(pin_prev_reg[gi] ^ chan_reg[gi][`CIRT_POL_BIT]));
            wire       hit = chan_reg[gi][`CIRT_EN_BIT] &
                             (chan_reg[gi][`CIRT_TYPE_BIT] ? edg : lvl);
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_meta_reg[gi] <= 2'h0;
                    pin_sync_reg[gi] <= 1'b0;
                    pin_prev_reg[gi] <= 1'b0;
                    chan_reg[gi] <= 14'h0000;
                    chan_pend_reg[gi] <= 1'b0;
                end else begin
                    pin_meta_reg[gi] <= {pin_meta_reg[gi][0], irq_pin[gi]};
                    pin_sync_reg[gi] <= pin_meta_reg[gi][1];
                    pin_prev_reg[gi] <= pin_sync_reg[gi];
                    if (wr_go && avs_address == ch_addr) begin
                        chan_reg[gi] <= avs_writedata[13:0] & 14'h2CE7;
                    end
                    // Set wins over read clear
                    if (hit) begin
                        chan_pend_reg[gi] <= 1'b1;
                    end else if (rd_go && avs_address == ch_addr) begin
                        chan_pend_reg[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Per-context control, soft interrupts, timers and wake decision
    generate
        for (gi = 0; gi < NCTX; gi = gi + 1) begin : g_ctx
            localparam integer OFS = gi * 4;
            localparam integer CID = gi;
            wire [7:0] c_addr = `CIRT_CTX_CTRL_BASE + OFS[7:0];
            wire [7:0] s_addr = `CIRT_SOFT_CTRL_BASE + OFS[7:0];
            wire [7:0] t_addr = `CIRT_SOFT_TRIG_BASE + OFS[7:0];
            wire [7:0] n_addr = `CIRT_TMR_CNT_BASE + OFS[7:0];
            wire [7:0] m_addr = `CIRT_STATUS_MASK;
            wire [1:0] st = ctrl_reg[gi][1:0];
            wire [1:0] im = ctrl_reg[gi][`CIRT_IMODE_HI:`CIRT_IMODE_LO];
            wire       over = run_reg[gi] && (cnt_reg[gi] > limit_full);
            wire       ovt_new = over & ~ovt_seen_reg[gi];
            reg        qual;
            integer    k;
            always @* begin
                qual = 1'b0;
                for (k = 0; k < NCHAN; k = k + 1) begin
                    if (chan_pend_reg[k] && chan_reg[k][`CIRT_CTXF_HI:`CIRT_CTXF_LO] == CID[2:0] &&
                        chan_reg[k][`CIRT_PRI_HI:`CIRT_PRI_LO] >= mask_reg[gi]) begin
                        qual = 1'b1;
                    end
                end
                if (soft_pend_reg[gi] && soft_reg[gi][`CIRT_EN_BIT] &&
                    soft_reg[gi][`CIRT_PRI_HI:`CIRT_PRI_LO] >= mask_reg[gi]) begin
                    qual = 1'b1;
                end
                if (gi == 0 && (ovt_seen_reg & ~slice_reg) != 0 && `CIRT_OVT_PRI >= mask_reg[gi]) begin
                    qual = 1'b1;
                end
                if (ovt_seen_reg[gi] && slice_reg[gi]) begin
                    qual = 1'b1;
                end
            end
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl_reg[gi] <= (gi == 0) ? `CIRT_CTX0_RESET : `CIRT_CTXN_RESET;
                    mask_reg[gi] <= 3'h0;
                    soft_reg[gi] <= 14'h0000;
                    soft_pend_reg[gi] <= 1'b0;
                    soft_sig_reg[gi] <= 32'h00000000;
                    cnt_reg[gi] <= 24'h000000;
                    ovt_seen_reg[gi] <= 1'b0;
                    ctx_wake[gi] <= 1'b0;
                    ctx_stack[gi] <= 1'b0;
                    ctx_vector[gi] <= 1'b0;
                    ctx_overtime[gi] <= 1'b0;
                end else begin
                    ctx_wake[gi] <= 1'b0;
                    ctx_stack[gi] <= 1'b0;
                    ctx_vector[gi] <= 1'b0;
                    ctx_overtime[gi] <= ovt_new;
                    if (wr_go && avs_address == c_addr) begin
                        ctrl_reg[gi] <= (avs_writedata[CW-1:0] & 16'h6703) | `CIRT_CTRL_ONES;
                    end else if (qual) begin
                        case (im)
                            `CIRT_IM_STD: begin
                                // Halted contexts leave only by a write
                                if (st != `CIRT_ST_HALT) begin
                                    ctx_stack[gi] <= 1'b1;
                                    ctx_vector[gi] <= 1'b1;
                                    ctx_wake[gi] <= 1'b1;
                                end
                                if (st == `CIRT_ST_NRDY) ctrl_reg[gi][1:0] <= `CIRT_ST_RDY;
                            end
                            `CIRT_IM_FAST: begin
                                if (st == `CIRT_ST_NRDY) begin
                                    ctx_vector[gi] <= 1'b1;
                                    ctx_wake[gi] <= 1'b1;
                                    ctrl_reg[gi][1:0] <= `CIRT_ST_RDY;
                                end
                            end
                            `CIRT_IM_SINGLE: begin
                                if (st == `CIRT_ST_NRDY) begin
                                    ctx_wake[gi] <= 1'b1;
                                    ctrl_reg[gi][1:0] <= `CIRT_ST_RDY;
                                end
                            end
                            default: begin
                                ctx_wake[gi] <= 1'b0;
                            end
                        endcase
                    end
                    if (wr_go && avs_address == m_addr && gi == 0) begin
                        mask_reg[gi] <= mask_reg[gi];
                    end
                    if (wr_go && avs_address == `CIRT_STATUS_MASK) begin
                        mask_reg[gi] <= avs_writedata[gi*4 +: 3];
                    end
                    if (wr_go && avs_address == s_addr) begin
                        soft_reg[gi] <= avs_writedata[13:0] & 14'h20E0;
                    end
                    if (wr_go && avs_address == t_addr) begin
                        soft_sig_reg[gi] <= avs_writedata;
                        soft_pend_reg[gi] <= soft_reg[gi][`CIRT_EN_BIT];
                    end else if (rd_go && avs_address == s_addr) begin
                        soft_pend_reg[gi] <= 1'b0;
                    end
                    // Clear and direct write take precedence over a tick
                    if (wr_go && avs_address == `CIRT_TMR_CLEAR && avs_writedata[gi]) begin
                        cnt_reg[gi] <= 24'h000000;
                        ovt_seen_reg[gi] <= 1'b0;
                    end else if (wr_go && avs_address == n_addr) begin
                        cnt_reg[gi] <= avs_writedata[23:0];
                        ovt_seen_reg[gi] <= 1'b0;
                    end else begin
                        if (run_reg[gi] && tick) cnt_reg[gi] <= cnt_reg[gi] + 24'h000001;
                        if (ovt_new) ovt_seen_reg[gi] <= 1'b1;
                    end
                end
            end
            always @* ctx_state[gi*2 +: 2] = st;
        end
    endgenerate

    // Lowest faulting context recorded
    wire [NCTX-1:0] g_ctx_ovt_any;
    reg  [7:0]      ovt_id;
    integer         j;
    generate
        for (gi = 0; gi < NCTX; gi = gi + 1) begin : g_ovt
            assign g_ctx_ovt_any[gi] = run_reg[gi] && (cnt_reg[gi] > limit_full) && !ovt_seen_reg[gi];
        end
    endgenerate
    always @* begin
        ovt_id = 8'h00;
        for (j = NCTX - 1; j >= 0; j = j - 1) begin
            if (g_ctx_ovt_any[j]) ovt_id = {5'h00, j[2:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared registers and divider
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 4'h0;
            idle_cnt_reg <= 24'h000000;
            run_reg <= {NCTX{1'b0}};
            slice_reg <= {NCTX{1'b0}};
            idle_en_reg <= 1'b0;
            limit_reg <= 15'h0000;
            fault_ctx_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 4'h1;
            if (wr_go && avs_address == `CIRT_TMR_ENABLE) begin
                idle_en_reg <= avs_writedata[`CIRT_IDLE_BIT];
                run_reg <= avs_writedata[NCTX-1:0];
                slice_reg <= avs_writedata[`CIRT_MODE_LO +: NCTX];
            end
            if (wr_go && avs_address == `CIRT_TIME_LIMIT) begin
                limit_reg <= avs_writedata[`CIRT_LIMIT_HI:`CIRT_LIMIT_LO];
            end
            if (wr_go && avs_address == `CIRT_TMR_CLEAR && avs_writedata[`CIRT_IDLE_BIT]) begin
                idle_cnt_reg <= 24'h000000;
            end else if (idle_en_reg && tick && ctx_running == {NCTX{1'b0}}) begin
                idle_cnt_reg <= idle_cnt_reg + 24'h000001;
            end
            if (|(ovt_seen_reg ^ ovt_seen_reg) || |(ctx_overtime & ~slice_reg)) begin
                fault_ctx_reg <= fault_ctx_reg;
            end
            if (wr_go && avs_address == `CIRT_FAULT_CTX) begin
                fault_ctx_reg <= avs_writedata[7:0];
            end else if (|g_ctx_ovt_any) begin
                fault_ctx_reg <= ovt_id;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux and acknowledge
    reg [31:0] rd_val;
    integer    r;
    always @* begin
        rd_val = 32'h00000000;
        for (r = 0; r < NCHAN; r = r + 1) begin
            if (avs_address == `CIRT_CHAN_BASE + {r[5:0], 2'b00}) begin
                rd_val = {18'h00000, chan_reg[r] | ({13'h0000, chan_pend_reg[r]} << `CIRT_STAT_BIT)};
            end
        end
        for (r = 0; r < NCTX; r = r + 1) begin
            if (avs_address == `CIRT_CTX_CTRL_BASE + {r[5:0], 2'b00}) begin
                rd_val = {16'h0000, ctrl_reg[r]};
            end else if (avs_address == `CIRT_TMR_CNT_BASE + {r[5:0], 2'b00}) begin
                rd_val = {8'h00, cnt_reg[r]};
            end else if (avs_address == `CIRT_SOFT_CTRL_BASE + {r[5:0], 2'b00}) begin
                rd_val = {18'h00000, soft_reg[r] | ({13'h0000, soft_pend_reg[r]} << `CIRT_STAT_BIT)};
            end else if (avs_address == `CIRT_SOFT_TRIG_BASE + {r[5:0], 2'b00}) begin
                rd_val = soft_sig_reg[r];
            end
        end
        if (avs_address == `CIRT_FAULT_CTX) begin
            rd_val = {24'h000000, fault_ctx_reg};
        end else if (avs_address == `CIRT_TMR_ENABLE) begin
            // Mode bits at 20..16, enables at 4..0
            rd_val = {idle_en_reg, 10'h000, slice_reg, 11'h000, run_reg};
        end else if (avs_address == `CIRT_TIME_LIMIT) begin
            rd_val = {8'h00, limit_full};
        end else if (avs_address == `CIRT_IDLE_CNT) begin
            rd_val = {8'h00, idle_cnt_reg};
        end else if (avs_address == `CIRT_STATUS_MASK) begin
            rd_val = {12'h000, 1'b0, mask_reg[4], 1'b0, mask_reg[3], 1'b0, mask_reg[2],
                      1'b0, mask_reg[1], 1'b0, mask_reg[0]};
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
            if (rd_go) avs_readdata <= rd_val;
        end
    end

endmodule // cirt_regs

// File: verilog/cirt_map.vh
// Purpose: Register offsets, field positions and reset values for the context interrupt and timer block
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef CIRT_MAP_VH
`define CIRT_MAP_VH

// Register byte offsets
`define CIRT_CHAN_BASE       8'h00
`define CIRT_FAULT_CTX       8'h20
`define CIRT_CTX_CTRL_BASE   8'h24
`define CIRT_TMR_ENABLE      8'h38
`define CIRT_TMR_CNT_BASE    8'h3C
`define CIRT_TIME_LIMIT      8'h50
`define CIRT_TMR_CLEAR       8'h54
`define CIRT_IDLE_CNT        8'h58
`define CIRT_SOFT_CTRL_BASE  8'h5C
`define CIRT_SOFT_TRIG_BASE  8'h70
`define CIRT_STATUS_MASK     8'h84

// Channel and soft interrupt control fields
`define CIRT_EN_BIT          13
`define CIRT_STAT_BIT        12
`define CIRT_POL_BIT         11
`define CIRT_TYPE_BIT        10
`define CIRT_PRI_HI          7
`define CIRT_PRI_LO          5
`define CIRT_CTXF_HI         2
`define CIRT_CTXF_LO         0

// Context control fields
`define CIRT_IMODE_HI        14
`define CIRT_IMODE_LO        13
`define CIRT_CPRI_HI         10
`define CIRT_CPRI_LO         8
`define CIRT_CTX0_RESET      16'h1F02
`define CIRT_CTXN_RESET      16'h1800
`define CIRT_CTRL_ONES       16'h1800

// Timer enable, clear and time limit fields
`define CIRT_IDLE_BIT        31
`define CIRT_MODE_LO         16
`define CIRT_LIMIT_HI        23
`define CIRT_LIMIT_LO        9

// Encodings and timing
`define CIRT_ST_HALT         2'h0
`define CIRT_ST_NRDY         2'h1
`define CIRT_ST_RDY          2'h2
`define CIRT_IM_STD          2'h0
`define CIRT_IM_FAST         2'h1
`define CIRT_IM_SINGLE       2'h3
`define CIRT_OVT_PRI         3'h6
`define CIRT_TICK_DIV        16
`define CIRT_TICK_LAST       4'hF

`endif

// File: testbench/cirt_regs_chk.sv
// Purpose: Port-level assertions for cirt_regs
// Assumes: Bus master holds each request until waitrequest is low
// Notes:   Bound into every cirt_regs instance
`timescale 1ns/100ps
module cirt_regs_chk #(
    parameter NCTX  = 5,
    parameter NCHAN = 8
) (
    // Clock and reset
    input wire              sys_clk,
    input wire              rst_n,
    // Bus
    input wire              avs_read,
    input wire              avs_write,
    input wire [31:0]       avs_readdata,
    input wire              avs_waitrequest,
    // Core side
    input wire [NCTX-1:0]   ctx_wake,
    input wire [NCTX-1:0]   ctx_stack,
    input wire [NCTX-1:0]   ctx_vector,
    input wire [NCTX-1:0]   ctx_overtime,
    input wire [NCTX*2-1:0] ctx_state
);
    wire [NCTX-1:0] halt_vec;
    wire [NCTX-1:0] bad_vec;
    genvar gi;
    generate
        for (gi = 0; gi < NCTX; gi = gi + 1) begin : g_ctx
            assign halt_vec[gi] = (ctx_state[2*gi +: 2] == 2'h0);
            assign bad_vec[gi]  = &ctx_state[2*gi +: 2];
        end
    endgenerate
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    a_wait_first: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
        else $error("first request cycle not stalled");
    a_wait_second: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait state");
    a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without a request");
    a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    a_state_legal: assert property (bad_vec == '0)
        else $error("context state holds an unused code");
    // A halted context may leave only through a register write
    a_halt_sticky: assert property (!avs_write && !$past(avs_write) |=> (~halt_vec & $past(halt_vec)) == '0)
        else $error("halted context left without a write");
    a_halt_no_wake: assert property (((ctx_wake | ctx_stack | ctx_vector) & $past(halt_vec)) == '0)
        else $error("halted context was woken");
    a_ot_pulse: assert property (ctx_overtime != '0 |=> ctx_overtime == '0)
        else $error("overtime pulse longer than one cycle");
endmodule // cirt_regs_chk

bind cirt_regs cirt_regs_chk #(.NCTX(NCTX), .NCHAN(NCHAN)) cirt_regs_chk_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ctx_wake(ctx_wake),
    .ctx_stack(ctx_stack), .ctx_vector(ctx_vector), .ctx_overtime(ctx_overtime), .ctx_state(ctx_state));

// File: testbench/cirt_core_model.sv
// Purpose: Core and interrupt source stand-in for cirt_regs
// Assumes: Sources drive their pins at all times
// Notes:   Runs the lowest numbered ready context
`timescale 1ns/100ps
module cirt_core_model #(
    parameter NCTX = 5
) (
    // Clock and reset
    input  wire              sys_clk,
    input  wire              rst_n,
    // Commands from the bench
    input  wire [7:0]        irq_drive,
    // Device side
    input  wire [NCTX*2-1:0] ctx_state,
    output wire [7:0]        irq_pin,
    output logic [NCTX-1:0]  ctx_running
);
    integer          k;
    logic [NCTX-1:0] pick;
    assign irq_pin = irq_drive;
    // Simplest scheduler; priority order is not modelled
    always @* begin
        pick = '0;
        for (k = NCTX - 1; k >= 0; k = k - 1) begin
            if (ctx_state[2*k +: 2] == 2'h2) begin
                pick    = '0;
                pick[k] = 1'b1;
            end
        end
    end
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            ctx_running <= '0;
        else
            ctx_running <= pick;
    end
endmodule // cirt_core_model

// File: testbench/testbench.sv
// Purpose: Self-checking bench for cirt_regs
// Assumes: One wait state per bus access
// Notes:   Seeded random values mixed with fixed corner rows
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
$display("CHECK FAILED at %0t: got %h want %h", $time, (g), (e)); end end
module testbench;
    logic        sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [7:0]  avs_address, irq_drive, irq_pin, a;
    logic [31:0] avs_writedata, avs_readdata, rv, w;
    logic [4:0]  ctx_running, ctx_wake, ctx_stack, ctx_vector, ctx_overtime;
    logic [4:0]  acc_w, acc_s, acc_v, acc_o;
    logic [9:0]  ctx_state;
    int          bad_count, n_checks, i;
    logic [15:0] t_ctl [10] = '{16'h2CE1, 16'h2CE1, 16'h2CE1, 16'h2CE1, 16'h2CE1,
                                16'h0CE1, 16'h2CC1, 16'h24E1, 16'h20E1, 16'h20E0};
    logic [1:0]  t_md [10] = '{2'h0, 2'h1, 2'h3, 2'h1, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1};
    logic [1:0]  t_st [10] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1};
    logic [2:0]  t_msk [10] = '{3'h7, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h0, 3'h0, 3'h0};
    logic [2:0]  t_exp [10] = '{3'h7, 3'h5, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h7, 3'h5};
    cirt_regs cirt_regs_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq_pin(irq_pin), .ctx_running(ctx_running),
        .ctx_wake(ctx_wake), .ctx_stack(ctx_stack), .ctx_vector(ctx_vector),
        .ctx_overtime(ctx_overtime), .ctx_state(ctx_state));
    cirt_core_model cirt_core_model_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .irq_drive(irq_drive), .ctx_state(ctx_state),
        .irq_pin(irq_pin), .ctx_running(ctx_running));
    ////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Overtime and FAST or SINGLE mode pulses are one cycle wide, so latch them all
    always @(negedge sys_clk) begin
        acc_w |= ctx_wake;
        acc_s |= ctx_stack;
        acc_v |= ctx_vector;
        acc_o |= ctx_overtime;
    end
    task automatic clr;
        acc_w = '0;
        acc_s = '0;
        acc_v = '0;
        acc_o = '0;
    endtask
    task automatic bus(input logic rd_en, input logic [7:0] ad, input logic [31:0] wd);
        int n;
        @(posedge sys_clk);
        avs_read      <= rd_en;
        avs_write     <= !rd_en;
        avs_address   <= ad;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            bad_count++;
            $display("CHECK FAILED at %0t: bus timeout", $time);
            finish_test();
        end
        rv = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        bus(1'b0, ad, wd);
    endtask
    task automatic rd(input logic [7:0] ad);
        bus(1'b1, ad, 32'h0);
    endtask
    task automatic pulse(input logic [2:0] ch, input logic pol);
        @(posedge sys_clk);
        irq_drive[ch] <= pol;
        repeat (4) @(posedge sys_clk);
        irq_drive[ch] <= ~pol;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        rst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        irq_drive = 8'h00;
        clr();
        void'($urandom(30532));
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 5; i++) begin
            rd(8'h24 + 8'(4 * i));
            `CHK(rv, (i == 0) ? 32'h00001F02 : 32'h00001800)
        end
        rd(8'hFC);
        `CHK(rv, 32'h0)
        for (i = 0; i < 6; i++) begin
            w = $urandom;
            w[1:0] = w[0] ? 2'h1 : {w[1], 1'b0};
            wr(8'h30, w);
            rd(8'h30);
            `CHK(rv, (w & 32'h00006703) | 32'h00001800)
            w = $urandom | 32'h00000200;
            wr(8'h50, w);
            rd(8'h50);
            `CHK(rv, w & 32'h00FFFE00)
            w = $urandom;
            wr(8'h48, w);
            rd(8'h48);
            `CHK(rv[23:0], w[23:0])
            w = $urandom;
            wr(8'h38, w);
            rd(8'h38);
            `CHK(rv, w & 32'h801F001F)
            wr(8'h38, 32'h0);
            wr(8'h54, 32'h8000001F);
            rd(8'h54);
            `CHK(rv, 32'h0)
            rd(8'h48);
            `CHK(rv, 32'h0)
        end
        $display("test registers done");
        for (i = 0; i < 10; i++) begin
            a = (i == 9) ? 8'h60 : 8'($urandom_range(7) * 4);
            irq_drive <= {8{~t_ctl[i][11]}};
            wr(8'h84, {25'h0, t_msk[i], 4'h0});
            wr(8'h28, {17'h0, t_md[i], 11'h0, t_st[i]});
            wr(a, {16'h0, t_ctl[i]});
            clr();
            if (i == 9)
                wr(8'h74, 32'hA5A5A5A5);
            else
                pulse(a[4:2], t_ctl[i][11]);
            repeat (30) @(posedge sys_clk);
            `CHK(acc_w, {3'h0, t_exp[i][2], 1'b0})
            `CHK(acc_s, {3'h0, t_exp[i][1], 1'b0})
            `CHK(acc_v, {3'h0, t_exp[i][0], 1'b0})
            // Every enabled row latched a pending bit; reading it clears it
            rd(a);
            `CHK(rv, {16'h0, t_ctl[i] | {3'h0, t_ctl[i][13], 12'h0}})
            rd(a);
            `CHK(rv[12], 1'b0)
            wr(a, 32'h0);
        end
        $display("test interrupts done");
        wr(8'h54, 32'h0000001F);
        wr(8'h38, 32'h00000001);
        repeat (320) @(posedge sys_clk);
        rd(8'h3C);
        `CHK(rv >= 32'h13 && rv <= 32'h15, 1'b1)
        wr(8'h38, 32'h0);
        rd(8'h3C);
        w = rv;
        repeat (48) @(posedge sys_clk);
        rd(8'h3C);
        `CHK(rv, w)
        // Count at the limit must not fault until it passes it
        wr(8'h50, 32'h00000200);
        wr(8'h40, 32'h00000200);
        clr();
        wr(8'h38, 32'h00000002);
        repeat (40) @(posedge sys_clk);
        `CHK(acc_o, 5'h02)
        rd(8'h20);
        `CHK(rv[7:0], 8'h01)
        wr(8'h2C, 32'h00000002);
        wr(8'h44, 32'h00000200);
        clr();
        wr(8'h38, 32'h00040004);
        repeat (40) @(posedge sys_clk);
        `CHK(acc_o, 5'h04)
        `CHK(ctx_state[5:4], 2'h2)
        $display("test timers done");
        // Idle timer runs only while no context executes
        for (i = 0; i < 5; i++)
            wr(8'h24 + 8'(4 * i), 32'h0);
        wr(8'h54, 32'h80000000);
        wr(8'h38, 32'h80000000);
        repeat (160) @(posedge sys_clk);
        rd(8'h58);
        `CHK(rv >= 32'h9 && rv <= 32'hB, 1'b1)
        wr(8'h38, 32'h0);
        wr(8'h54, 32'h80000000);
        rd(8'h58);
        `CHK(rv, 32'h0)
        $display("test idle timer done");
        finish_test();
    end
endmodule // testbench
